// >>> src/flash_cmd_defs.svh
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// =====================================================
// Instruction codes
`define OPC_PAGE_PROG      8'h02
`define OPC_PAGE_PROG4     8'h12
`define OPC_SECTOR_ERASE   8'h20
`define OPC_SECTOR_ERASE4  8'h21
`define OPC_HALF_ERASE     8'h52
`define OPC_HALF_ERASE4    8'h53
`define OPC_BLOCK_ERASE    8'hD8
`define OPC_BLOCK_ERASE4   8'hDC
`define OPC_CHIP_ERASE     8'h60
`define OPC_CHIP_ERASE_ALT 8'hC7
`define OPC_SUSPEND        8'h75
`define OPC_RESUME         8'h7A
`define OPC_PROT_LOCK      8'hA6
`define OPC_SLEEP          8'hB9
`define OPC_SLEEP_EXIT     8'hAB
`define OPC_PTR_PROT       8'hFB
`define OPC_PTR_PROT4      8'hE3
`define OPC_STATUS1_RD     8'h05
`define OPC_STATUS2_RD     8'h07
`define OPC_ANY_RD         8'h65
`define OPC_CONFIG1_RD     8'h35
`define OPC_CONFIG3_RD     8'h33
`define OPC_CLEAR_STATUS   8'h30
`define OPC_RESET_EN       8'h66
`define OPC_RESET          8'h99
`define OPC_WRITE_EN       8'h06
`define OPC_WRITE_REG      8'h01

// =====================================================
// Register byte addresses
`define REG_CTRL     12'h000
`define REG_STATUS   12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00C
`define REG_LAST_OPC 12'h010

// =====================================================
// Field positions
`define ST_WIP      0
`define ST_WEL      1
`define ST_PERR     2
`define ST_EERR     3
`define ST_SUSP     4
`define ST_SLEEP    5
`define ST_NV_PROTECTION_LOCK_BIT   6
`define ST_STATUS_PROTECT1_BIT     7
`define ST_QUAD     8
`define ST_ADDR4    9
`define CT_DONE     0
`define CT_PFAIL    1
`define CT_EFAIL    2
`define CT_SETLOCK  3
`define CT_SETSRP1  4
`define CT_QUAD     5
`define CT_ADDR4    6
`define IRQ_OPCODE  0
`define IRQ_ERROR   1
`define IRQ_IGNORED 2
`define IRQ_RESET   3

// =====================================================
// Widths and reset values
`define ST_W        10
`define IRQ_W       4
`define OPC_BITS    4'h8
`define BITCNT_W    4
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define ZERO32      32'h0000_0000

`endif

// >>> src/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // Kind of array operation under way
  typedef enum logic [1:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_ERASE,
    OP_REGWRITE
  } op_kind_t;
  // Link capture states
  typedef enum logic [1:0] {
    LK_IDLE,
    LK_SHIFT,
    LK_DONE
  } link_state_t;
endpackage : flash_cmd_pkg

// >>> src/flash_cmd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.svh"

// Operation
// - decode sector, half, block, chip erases
// - suspend and resume opcodes
// - lock opcode writes nv lock bit
// - sleep enter, sleep exit opcodes
// - register write is self-timed operation
// - busy flag reports embedded operations
// - program and erase error flags
// - error keeps busy flag set
// - error state allows listed commands only
// - resets also leave error state
// - write enable precedes page program
// - soft reset keeps status_protect1_bit and lock
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter int AW = 12
) (
  // Clock and reset
  input  wire logic          I_MCLK,
  input  wire logic          I_RST_B,
  // Serial link
  input  wire logic          I_CS_B,
  input  wire logic          I_SCK,
  input  wire logic          I_SI,
  // Operation status
  output var  logic          O_OP_START,
  output var  flash_cmd_pkg::op_kind_t O_OP_KIND,
  output var  logic [7:0]    O_OP_CODE,
  output var  logic          O_BUSY,
  output var  logic          O_IRQ,
  // AXI4-Lite write
  input  wire logic [AW-1:0] S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output var  logic          S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output var  logic          S_AXI_WREADY,
  output var  logic [1:0]    S_AXI_BRESP,
  output var  logic          S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [AW-1:0] S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output var  logic          S_AXI_ARREADY,
  output var  logic [31:0]   S_AXI_RDATA,
  output var  logic [1:0]    S_AXI_RRESP,
  output var  logic          S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY
);
  import flash_cmd_pkg::*;

  // Register map needs five address bits; refuse narrower buses
  if (AW < 5) begin : g_aw_check
    $error("AW too small for register map");
  end

  // ===================================================
  // Decode helpers
  function automatic logic is_erase(input logic [7:0] c);
    is_erase = (c == `OPC_SECTOR_ERASE) || (c == `OPC_SECTOR_ERASE4) ||
               (c == `OPC_HALF_ERASE)   || (c == `OPC_HALF_ERASE4)   ||
               (c == `OPC_BLOCK_ERASE)  || (c == `OPC_BLOCK_ERASE4)  ||
               (c == `OPC_CHIP_ERASE)   || (c == `OPC_CHIP_ERASE_ALT);
  endfunction : is_erase

  function automatic logic err_allowed(input logic [7:0] c);
    err_allowed = (c == `OPC_STATUS1_RD) || (c == `OPC_STATUS2_RD) ||
                  (c == `OPC_ANY_RD)     || (c == `OPC_CONFIG1_RD) ||
                  (c == `OPC_CONFIG3_RD) || (c == `OPC_CLEAR_STATUS) ||
                  (c == `OPC_RESET_EN)   || (c == `OPC_RESET);
  endfunction : err_allowed

  // ===================================================
  // Pin synchronisers (two flops, first read only by second)
  logic [2:0] sync1_q;   // First stage
  logic [2:0] sync2_q;   // Second stage
  logic       sck_old_q; // Edge detect history
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync1_q   <= 3'h7;
      sync2_q   <= 3'h7;
      sck_old_q <= 1'h1;
    end else begin
      sync1_q   <= {I_CS_B, I_SCK, I_SI};
      sync2_q   <= sync1_q;
      sck_old_q <= sync2_q[1];
    end
  end
  logic cs_b_s;
  logic sck_rise;
  logic si_s;
  assign cs_b_s   = sync2_q[2];
  assign si_s     = sync2_q[0];
  assign sck_rise = sync2_q[1] & ~sck_old_q;

  // ===================================================
  // Instruction capture
  link_state_t lk_q, lk_d;          // Capture state
  logic [7:0]  shreg_q, shreg_d;    // Opcode shifter
  logic [3:0]  bits_q, bits_d;      // Bits taken so far
  logic        opc_stb;             // Whole opcode seen
  // Eight rising edges after chip select falls; rest of frame ignored
  always_comb begin
    lk_d    = lk_q;
    shreg_d = shreg_q;
    bits_d  = bits_q;
    opc_stb = 1'b0;
    case (lk_q)
      LK_IDLE: begin
        if (!cs_b_s) begin
          lk_d   = LK_SHIFT;
          bits_d = '0;
        end
      end
      LK_SHIFT: begin
        if (cs_b_s) begin
          lk_d = LK_IDLE; // Short frame dropped
        end else if (sck_rise) begin
          shreg_d = {shreg_q[6:0], si_s};
          bits_d  = bits_q + 4'h1;
          if (bits_q == (`OPC_BITS - 4'h1)) begin
            lk_d    = LK_DONE;
            opc_stb = 1'b1;
          end
        end
      end
      LK_DONE: begin
        if (cs_b_s) lk_d = LK_IDLE;
      end
      default: lk_d = LK_IDLE;
    endcase
  end
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lk_q    <= LK_IDLE;
      shreg_q <= 8'h00;
      bits_q  <= 4'h0;
    end else begin
      lk_q    <= lk_d;
      shreg_q <= shreg_d;
      bits_q  <= bits_d;
    end
  end
  logic [7:0] opc;
  assign opc = shreg_d;

  // ===================================================
  // Register bus state
  logic [6:0]         ctrl_q, ctrl_d;         // Software control
  logic [`IRQ_W-1:0]  irq_st_q, irq_st_d;     // Sticky events
  logic [`IRQ_W-1:0]  irq_mk_q, irq_mk_d;     // Event mask
  logic               bvalid_q, bvalid_d;
  logic [1:0]         bresp_q, bresp_d;
  logic               rvalid_q, rvalid_d;
  logic [31:0]        rdata_q, rdata_d;
  logic [1:0]         rresp_q, rresp_d;

  // ===================================================
  // Device state
  logic [`ST_W-1:0] st_q, st_d;     // Status bits
  op_kind_t         op_q, op_d;     // Operation in flight
  logic             reset_enable_cmd_q, reset_enable_cmd_d; // Reset armed
  logic             start_q, start_d;
  logic [7:0]       last_q, last_d;
  logic [`IRQ_W-1:0] ev;            // Events this cycle

  logic wr_go;
  logic [31:0] wd;
  assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
  assign wd    = S_AXI_WDATA;

  // Command interpreter and status
  always_comb begin
    logic err;
    logic ok;
    err     = st_q[`ST_PERR] | st_q[`ST_EERR];
    ok      = opc_stb & (!err | err_allowed(opc));
    st_d    = st_q;
    op_d    = op_q;
    reset_enable_cmd_d = reset_enable_cmd_q;
    start_d = 1'b0;
    last_d  = last_q;
    ev      = '0;
    if (opc_stb) begin
      ev[`IRQ_OPCODE] = ok;
      ev[`IRQ_IGNORED] = !ok;
      if (ok) last_d = opc;
    end
    if (ok) begin
      reset_enable_cmd_d = (opc == `OPC_RESET_EN);
      if (st_q[`ST_SLEEP]) begin
        if (opc == `OPC_SLEEP_EXIT) st_d[`ST_SLEEP] = 1'b0;
      end else if (st_q[`ST_WIP] && op_q != OP_NONE) begin
        if (opc == `OPC_SUSPEND && op_q != OP_REGWRITE) begin
          st_d[`ST_SUSP] = 1'b1;
          st_d[`ST_WIP]  = 1'b0;
        end
      end else begin
        case (opc)
          `OPC_WRITE_EN: st_d[`ST_WEL] = 1'b1;
          `OPC_PAGE_PROG, `OPC_PAGE_PROG4: begin
            if (st_q[`ST_WEL] && !st_q[`ST_SUSP]) begin
              op_d = OP_PROGRAM;
              st_d[`ST_WIP] = 1'b1;
              st_d[`ST_WEL] = 1'b0;
              start_d = 1'b1;
            end
          end
          `OPC_RESUME: begin
            if (st_q[`ST_SUSP]) begin
              st_d[`ST_SUSP] = 1'b0;
              st_d[`ST_WIP]  = 1'b1;
            end
          end
          `OPC_PROT_LOCK: begin
            if (st_q[`ST_WEL]) begin
              st_d[`ST_NV_PROTECTION_LOCK_BIT] = 1'b1;
              st_d[`ST_WEL] = 1'b0;
              st_d[`ST_WIP] = 1'b1;
              op_d = OP_REGWRITE;
              start_d = 1'b1;
            end
          end
          `OPC_WRITE_REG: begin
            if (st_q[`ST_WEL]) begin
              st_d[`ST_STATUS_PROTECT1_BIT] = ctrl_q[`CT_SETSRP1];
              st_d[`ST_WEL] = 1'b0;
              st_d[`ST_WIP] = 1'b1;
              op_d = OP_REGWRITE;
              start_d = 1'b1;
            end
          end
          `OPC_SLEEP: st_d[`ST_SLEEP] = 1'b1;
          `OPC_CLEAR_STATUS: begin
            st_d[`ST_PERR] = 1'b0;
            st_d[`ST_EERR] = 1'b0;
            st_d[`ST_WIP]  = 1'b0;
            op_d = OP_NONE;
          end
          default: begin
            if (is_erase(opc) && st_q[`ST_WEL] &&
                !st_q[`ST_SUSP]) begin
              op_d = OP_ERASE;
              st_d[`ST_WIP] = 1'b1;
              st_d[`ST_WEL] = 1'b0;
              start_d = 1'b1;
            end
          end
        endcase
      end
      if (err && opc == `OPC_CLEAR_STATUS) begin
        st_d[`ST_PERR] = 1'b0;
        st_d[`ST_EERR] = 1'b0;
        st_d[`ST_WIP]  = 1'b0;
        op_d = OP_NONE;
      end
      // Soft reset acts even while busy or erroring, but not asleep
      if (opc == `OPC_RESET && reset_enable_cmd_q && !st_q[`ST_SLEEP]) begin
        st_d = '0;
        st_d[`ST_NV_PROTECTION_LOCK_BIT] = st_q[`ST_NV_PROTECTION_LOCK_BIT];
        st_d[`ST_STATUS_PROTECT1_BIT]   = st_q[`ST_STATUS_PROTECT1_BIT];
        op_d = OP_NONE;
        ev[`IRQ_RESET] = 1'b1;
      end
    end
    // Array engine reports through the control register
    if (wr_go && S_AXI_AWADDR[AW-1:0] == AW'(`REG_CTRL) && S_AXI_WSTRB[0]
        && op_q != OP_NONE && st_q[`ST_WIP] && !err) begin
      if (wd[`CT_PFAIL] && op_q == OP_PROGRAM) begin
        st_d[`ST_PERR] = 1'b1;
        ev[`IRQ_ERROR] = 1'b1;
      end else if (wd[`CT_EFAIL] && op_q == OP_ERASE) begin
        st_d[`ST_EERR] = 1'b1;
        ev[`IRQ_ERROR] = 1'b1;
      end else if (wd[`CT_DONE]) begin
        st_d[`ST_WIP] = 1'b0;
        op_d = OP_NONE;
      end
    end
    if (st_d[`ST_PERR] | st_d[`ST_EERR]) st_d[`ST_WIP] = 1'b1;
    st_d[`ST_QUAD]  = ctrl_q[`CT_QUAD];
    st_d[`ST_ADDR4] = ctrl_q[`CT_ADDR4];
  end
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_q    <= '0;
      op_q    <= OP_NONE;
      reset_enable_cmd_q <= 1'b0;
      start_q <= 1'b0;
      last_q  <= 8'h00;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      reset_enable_cmd_q <= reset_enable_cmd_d;
      start_q <= start_d;
      last_q  <= last_d;
    end
  end

  // ===================================================
  // AXI4-Lite slave: both halves taken together, one cycle answer
  always_comb begin
    ctrl_d   = ctrl_q;
    irq_st_d = irq_st_q;
    irq_mk_d = irq_mk_q;
    bvalid_d = bvalid_q & ~S_AXI_BREADY;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q & ~S_AXI_RREADY;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = `RESP_OKAY;
      case (S_AXI_AWADDR)
        AW'(`REG_CTRL):
          if (S_AXI_WSTRB[0]) ctrl_d = {wd[6:5], 5'h00};
        AW'(`REG_IRQ_STAT):
          if (S_AXI_WSTRB[0]) irq_st_d = irq_st_q & ~wd[`IRQ_W-1:0];
        AW'(`REG_IRQ_MASK):
          if (S_AXI_WSTRB[0]) irq_mk_d = wd[`IRQ_W-1:0];
        AW'(`REG_STATUS), AW'(`REG_LAST_OPC): ;
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    irq_st_d = irq_st_d | ev; // Set wins over clear
    if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      case (S_AXI_ARADDR)
        AW'(`REG_CTRL):     rdata_d = {25'h0, ctrl_q};
        AW'(`REG_STATUS):   rdata_d = {22'h0, st_q};
        AW'(`REG_IRQ_STAT): rdata_d = {28'h0, irq_st_q};
        AW'(`REG_IRQ_MASK): rdata_d = {28'h0, irq_mk_q};
        AW'(`REG_LAST_OPC): rdata_d = {24'h0, last_q};
        default: begin
          rdata_d = `ZERO32;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_q   <= '0;
      irq_st_q <= '0;
      irq_mk_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end else begin
      ctrl_q   <= ctrl_d;
      irq_st_q <= irq_st_d;
      irq_mk_q <= irq_mk_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ===================================================
  // Outputs
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = S_AXI_ARVALID & ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign O_OP_START    = start_q;
  assign O_OP_KIND     = op_q;
  assign O_OP_CODE     = last_q;
  assign O_BUSY        = st_q[`ST_WIP];
  assign O_IRQ         = |(irq_st_q & irq_mk_q);
endmodule : flash_cmd_decoder
`default_nettype wire

// >>> testbench/flash_cmd_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checker
module flash_cmd_sva
  import flash_cmd_pkg::*;
#(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic     I_MCLK,
  input wire logic     I_RST_B,
  // Operation status
  input wire logic     O_OP_START,
  input wire op_kind_t O_OP_KIND,
  input wire logic     O_BUSY,
  input wire logic     O_IRQ,
  // Bus handshakes
  input wire logic     S_AXI_AWVALID,
  input wire logic     S_AXI_AWREADY,
  input wire logic     S_AXI_WVALID,
  input wire logic     S_AXI_WREADY,
  input wire logic     S_AXI_BVALID,
  input wire logic     S_AXI_BREADY,
  input wire logic     S_AXI_ARVALID,
  input wire logic     S_AXI_ARREADY,
  input wire logic     S_AXI_RVALID,
  input wire logic     S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  // Write accepted this edge
  logic wacc;
  assign wacc = S_AXI_AWVALID & S_AXI_WVALID & S_AXI_AWREADY;
  wr_answer_a: assert property (wacc |=> S_AXI_BVALID)
    else $error("write response missing");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response missing");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  wr_ready_a: assert property (S_AXI_AWREADY |->
    S_AXI_WREADY && S_AXI_WVALID && !S_AXI_BVALID)
    else $error("write ready out of turn");
  start_busy_a: assert property (O_OP_START |-> ##[0:1] O_BUSY)
    else $error("launch without busy");
  start_kind_a: assert property (O_OP_START |-> ##[0:1] O_OP_KIND != OP_NONE)
    else $error("launch without kind");
  start_pulse_a: assert property (O_OP_START |=> !O_OP_START)
    else $error("launch pulse too long");
  // Irq only drops after software touched it
  irq_clear_a: assert property ($fell(O_IRQ) |-> $past(wacc) || $past(wacc, 2))
    else $error("irq dropped by itself");
endmodule : flash_cmd_sva
bind flash_cmd_decoder flash_cmd_sva #(.AW(AW)) u_sva (.I_MCLK(I_MCLK),
  .I_RST_B(I_RST_B), .O_OP_START(O_OP_START), .O_OP_KIND(O_OP_KIND),
  .O_BUSY(O_BUSY), .O_IRQ(O_IRQ), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));
`default_nettype wire

// >>> testbench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host controller: single-line frames only
module spi_host_model (
  // Serial pins toward the device
  output var logic o_cs_b,
  output var logic o_sck,
  output var logic o_si
);
  // Idle: deselected, clock parked low
  initial begin
    o_cs_b = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  // Deselected data line keeps moving, so no stale bit looks valid
  always #250 if (o_cs_b) o_si = ~o_si;
  // One opcode frame, MSB first, 800 ns clock
  task automatic send(input logic [7:0] opc);
    #137 o_cs_b = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      o_si = opc[i];
      #400 o_sck = 1'b1;
      #400 o_sck = 1'b0;
    end
    #400 o_cs_b = 1'b1;
    #3000;
  endtask : send
endmodule : spi_host_model
`default_nettype wire

// >>> testbench/flash_cmd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.svh"
module flash_cmd_decoder_tb;
  import flash_cmd_pkg::*;
  // ==========================================
  // Signals
  logic clk, rst_b, cs_b, sck, si, op_start, busy, irq;
  op_kind_t    op_kind;
  logic [7:0]  op_code;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0]  rdy;
  int mismatches, checks_done;
  // Status bits under test (WEL left out: its clearing is unspecified)
  localparam logic [31:0] WRITE_IN_PROGRESS_FLAG = 32'h1 << `ST_WIP;
  localparam logic [31:0] PER = 32'h1 << `ST_PERR;
  localparam logic [31:0] EER = 32'h1 << `ST_EERR;
  localparam logic [31:0] SUS = 32'h1 << `ST_SUSP;
  localparam logic [31:0] SLP = 32'h1 << `ST_SLEEP;
  localparam logic [31:0] LCK = 32'h1 << `ST_NV_PROTECTION_LOCK_BIT;
  logic [7:0] ers [8] = '{`OPC_SECTOR_ERASE, `OPC_SECTOR_ERASE4,
    `OPC_HALF_ERASE, `OPC_HALF_ERASE4, `OPC_BLOCK_ERASE,
    `OPC_BLOCK_ERASE4, `OPC_CHIP_ERASE, `OPC_CHIP_ERASE_ALT};
  assign rdy = {rvalid, arready, bvalid, awready};
  // ==========================================
  // Design and far side
  spi_host_model u_host (.o_cs_b(cs_b), .o_sck(sck), .o_si(si));
  flash_cmd_decoder #(.AW(12)) u_dut (.I_MCLK(clk), .I_RST_B(rst_b),
    .I_CS_B(cs_b), .I_SCK(sck), .I_SI(si), .O_OP_START(op_start),
    .O_OP_KIND(op_kind), .O_OP_CODE(op_code), .O_BUSY(busy), .O_IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Negedge look equals what the next rising edge samples
  task automatic wait_hi(input int which);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rdy[which] !== 1'b1 && n < 200);
    if (n >= 200) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_hi
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    wait_hi(0);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    wait_hi(1);
    rr = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    wait_hi(2);
    @(posedge clk);
    arvalid <= 1'b0;
    wait_hi(3);
    rd = rdata;
    rr = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic st(input logic [31:0] exp, input string what);
    axi_rd(`REG_STATUS);
    check(what, rd & 32'h7D, exp);
  endtask : st
  task automatic op(input logic [7:0] c);
    u_host.send(c);
  endtask : op
  task automatic ctrl(input int b);
    axi_wr(`REG_CTRL, 32'h1 << b);
  endtask : ctrl
  // ==========================================
  // Main sequence
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    mismatches = 0;
    checks_done = 0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    st(32'h0, "reset status");
    axi_rd(12'h0FC);
    check("unmapped read", rr, `RESP_SLVERR);
    axi_wr(12'h0FC, 32'h1);
    check("unmapped write", rr, `RESP_SLVERR);
    axi_wr(`REG_IRQ_MASK, 32'h1);
    $display("test reset and map done");
    op(`OPC_SECTOR_ERASE);
    op(`OPC_PAGE_PROG);
    st(32'h0, "no enable no op");
    foreach (ers[i]) begin
      op(`OPC_WRITE_EN);
      op(ers[i]);
      st(WRITE_IN_PROGRESS_FLAG, "erase busy");
      check("busy pin", busy, 32'h1);
      check("erase kind", op_kind, OP_ERASE);
      check("code pin", op_code, ers[i]);
      axi_rd(`REG_LAST_OPC);
      check("erase code", rd & 32'hFF, {24'h0, ers[i]});
      check("irq up", irq, 32'h1);
      axi_wr(`REG_IRQ_STAT, 32'hF);
      check("irq cleared", irq, 32'h0);
      ctrl(`CT_DONE);
      st(32'h0, "erase done");
    end
    op(`OPC_WRITE_EN);
    op(`OPC_WRITE_REG);
    st(WRITE_IN_PROGRESS_FLAG, "reg write busy");
    ctrl(`CT_DONE);
    $display("test erase set done");
    op(`OPC_WRITE_EN);
    op(`OPC_SECTOR_ERASE);
    op(`OPC_SUSPEND);
    st(SUS, "suspended");
    op(`OPC_RESUME);
    st(WRITE_IN_PROGRESS_FLAG, "resumed");
    ctrl(`CT_DONE);
    $display("test suspend done");
    op(`OPC_WRITE_EN);
    op(`OPC_PAGE_PROG);
    ctrl(`CT_PFAIL);
    st(WRITE_IN_PROGRESS_FLAG | PER, "program error");
    op(`OPC_WRITE_EN);
    axi_rd(`REG_LAST_OPC);
    check("refused code", rd & 32'hFF, 32'h02);
    op(`OPC_STATUS2_RD);
    axi_rd(`REG_LAST_OPC);
    check("allowed code", rd & 32'hFF, 32'h07);
    op(`OPC_CLEAR_STATUS);
    st(32'h0, "cleared");
    $display("test program error done");
    op(`OPC_WRITE_EN);
    op(`OPC_BLOCK_ERASE);
    ctrl(`CT_EFAIL);
    st(WRITE_IN_PROGRESS_FLAG | EER, "erase error");
    op(`OPC_RESET_EN);
    op(`OPC_STATUS1_RD);
    op(`OPC_RESET);
    st(WRITE_IN_PROGRESS_FLAG | EER, "reset disarmed");
    op(`OPC_RESET_EN);
    op(`OPC_RESET);
    st(32'h0, "soft reset");
    op(`OPC_WRITE_EN);
    op(`OPC_PROT_LOCK);
    ctrl(`CT_DONE);
    st(LCK, "lock set");
    op(`OPC_RESET_EN);
    op(`OPC_RESET);
    st(LCK, "lock kept");
    $display("test reset paths done");
    op(`OPC_SLEEP);
    st(LCK | SLP, "asleep");
    op(`OPC_WRITE_EN);
    op(`OPC_SECTOR_ERASE);
    st(LCK | SLP, "asleep no op");
    op(`OPC_SLEEP_EXIT);
    st(LCK, "awake");
    op(`OPC_WRITE_EN);
    op(`OPC_PAGE_PROG);
    ctrl(`CT_PFAIL);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    st(32'h0, "hard reset");
    $display("test sleep and hard reset done");
    wrap_up();
  end
endmodule : flash_cmd_decoder_tb
`default_nettype wire
